// ### rtl/ucs_pkg.sv
package ucs_pkg;
  // ==========================================
  // command byte
  localparam logic [7:0] UCS_CMD_NOOP = 8'h00;
  localparam int UCS_TYPE_MSB = 7;
  localparam int UCS_TYPE_LSB = 6;
  localparam logic [1:0] UCS_TYPE_IDLE = 2'h0;
  localparam logic [1:0] UCS_TYPE_TX = 2'h1;
  localparam logic [1:0] UCS_TYPE_WR = 2'h2;
  localparam logic [1:0] UCS_TYPE_RD = 2'h3;
  localparam logic [5:0] UCS_PAY_EXT = 6'h2f;
  // ==========================================
  // status byte fields
  localparam int UCS_LS_LSB = 0;
  localparam int UCS_VB_LSB = 2;
  localparam int UCS_EV_LSB = 4;
  localparam int UCS_ID_BIT = 6;
  localparam int UCS_ALT_BIT = 7;
  localparam logic [7:0] UCS_STATUS_RST = 8'h00;
  localparam logic [1:0] UCS_VB_BELOW_END = 2'h0;
  localparam logic [1:0] UCS_VB_END_TO_VLD = 2'h1;
  localparam logic [1:0] UCS_VB_VLD_TO_HOST = 2'h2;
  localparam logic [1:0] UCS_VB_HOST_VLD = 2'h3;
  localparam logic [1:0] UCS_EV_NONE = 2'h0;
  localparam logic [1:0] UCS_EV_ACTIVE = 2'h1;
  localparam logic [1:0] UCS_EV_DISC = 2'h2;
  localparam logic [1:0] UCS_EV_ERROR = 2'h3;
  // ==========================================
  // line state
  localparam logic [1:0] UCS_SEL_HS = 2'h0;
  localparam logic [1:0] UCS_SEL_LS = 2'h2;
  localparam logic [1:0] UCS_LS_SQUELCH = 2'h0;
  localparam logic [1:0] UCS_LS_NOT_SQUELCH = 2'h1;
  // ==========================================
  // timing
  localparam int UCS_TURNAROUND_CYCLES = 1;

  typedef enum logic [3:0] {
    S_IDLE, S_ACC, S_ADDR, S_WDATA, S_WSTP, S_TX,
    S_RTA, S_RDRV, S_SUP, S_SDRV
  } ucs_state_t;
endpackage

// ### rtl/ucs_line_enc.sv
`timescale 1ns/1ps
module ucs_line_enc
  import ucs_pkg::*;
(
  input wire logic dp_i, // dp level
  input wire logic dm_i, // dm level
  input wire logic squelch_i, // hs squelch active
  input wire logic hs_diff_i, // hs differential receiver
  input wire logic [1:0] xcvr_select_i, // transceiver select
  input wire logic term_select_i, // termination select
  input wire logic chirp_mode_i, // host chirp opmode
  input wire logic host_role_i, // host role
  output logic [1:0] line_o // encoded line state
);
  // ==========================================
  // decode
  // role picks table
  wire chirp_w = host_role_i ? chirp_mode_i : term_select_i;
  wire hs_w = (xcvr_select_i == UCS_SEL_HS);
  wire ls_host_w = host_role_i && (xcvr_select_i == UCS_SEL_LS);
  wire [1:0] chirp_ls_w = {~hs_diff_i, hs_diff_i};
  wire [1:0] hs_ls_w = chirp_w ? chirp_ls_w : UCS_LS_NOT_SQUELCH;
  wire [1:0] hs_code_w = squelch_i ? UCS_LS_SQUELCH : hs_ls_w;
  wire [1:0] fs_code_w = ls_host_w ? {dp_i, dm_i} : {dm_i, dp_i};

  assign line_o = hs_w ? hs_code_w : fs_code_w;
endmodule

// ### rtl/ucs_port.sv
`timescale 1ns/1ps
module ucs_port
  import ucs_pkg::*;
(
  input wire logic clk_i, // clock
  input wire logic reset_i, // async reset, high
  input wire logic [7:0] data_i, // bus sampled in
  output logic [7:0] data_o, // bus driven out
  output logic data_oe_n_o, // bus drive enable, low
  input wire logic stp_i, // link stop
  output logic dir_o, // bus direction
  output logic nxt_o, // next / accept
  input wire logic dp_i, // dp level
  input wire logic dm_i, // dm level
  input wire logic squelch_i, // hs squelch
  input wire logic hs_diff_i, // hs diff receiver
  input wire logic [1:0] xcvr_select_i, // transceiver select
  input wire logic term_select_i, // termination select
  input wire logic chirp_mode_i, // host chirp opmode
  input wire logic host_role_i, // host role
  input wire logic session_end_flag_i, // below session end
  input wire logic session_valid_flag_i, // session valid
  input wire logic host_vbus_cmp_i, // host vbus comparator
  input wire logic fault_i, // external fault level
  input wire logic external_indicator_select_i, // use fault
  input wire logic indicator_passthrough_i, // pass fault
  input wire logic rx_active_i, // receive active
  input wire logic rx_error_i, // receive error
  input wire logic host_disconnect_i, // host disconnect
  input wire logic otg_role_pin_level_i, // id pin
  input wire logic bvalid_i, // b-session valid
  input wire logic bvalid_rise_en_i, // rise event enable
  input wire logic bvalid_fall_en_i, // fall event enable
  input wire logic low_power_i, // low power / serial
  input wire logic [7:0] rd_data_i, // register read data
  output logic [7:0] reg_addr_o, // register address
  output logic [7:0] reg_wdata_o, // register write data
  output logic reg_wr_o, // write strobe
  output logic reg_rd_o, // read strobe
  output logic [3:0] tx_pid_o, // packet identifier
  output logic [7:0] tx_byte_o, // transmit byte
  output logic tx_valid_o, // transmit byte strobe
  output logic tx_start_o, // line transmit start
  output logic tx_end_o // transmit end
);
  // ==========================================
  // state
  ucs_state_t st_q, st_d;
  logic dir_q, dir_d;
  logic nxt_q, nxt_d;
  logic [7:0] data_q, data_d;
  logic oe_n_q, oe_n_d;
  logic ta_q;
  logic [7:0] cmd_q, cmd_d;
  logic [6:0] sent_q, sent_d;
  logic alt_q, alt_clr_d;
  logic bval_q;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wdata_q, wdata_d;
  logic wr_q, wr_d;
  logic rd_q, rd_d;
  logic [7:0] txb_q, txb_d;
  logic txv_q, txv_d;
  logic txs_q, txs_d;
  logic txe_q, txe_d;
  logic first_q, first_d;
  logic [1:0] line_w;

  // ==========================================
  // status byte
  ucs_line_enc u_line (
    .dp_i(dp_i),
    .dm_i(dm_i),
    .squelch_i(squelch_i),
    .hs_diff_i(hs_diff_i),
    .xcvr_select_i(xcvr_select_i),
    .term_select_i(term_select_i),
    .chirp_mode_i(chirp_mode_i),
    .host_role_i(host_role_i),
    .line_o(line_w)
  );

  wire fault_sel_w = external_indicator_select_i && indicator_passthrough_i;
  wire host_vbus_valid_flag_w = fault_sel_w ? fault_i : host_vbus_cmp_i;
  wire [1:0] vb_lo_w = session_end_flag_i ? UCS_VB_BELOW_END : UCS_VB_END_TO_VLD;
  wire [1:0] vb_mid_w = session_valid_flag_i ? UCS_VB_VLD_TO_HOST : vb_lo_w;
  wire [1:0] vbus_w = host_vbus_valid_flag_w ? UCS_VB_HOST_VLD : vb_mid_w;
  wire [1:0] act_w = rx_error_i ? UCS_EV_ERROR : UCS_EV_ACTIVE;
  wire [1:0] ev_act_w = rx_active_i ? act_w : UCS_EV_NONE;
  wire [1:0] rxev_w = host_disconnect_i ? UCS_EV_DISC : ev_act_w;
  wire [7:0] status_w = {alt_q, otg_role_pin_level_i, rxev_w, vbus_w, line_w};

  wire changed_w = (status_w[6:0] != sent_q) || alt_q;
  wire send_w = changed_w && !low_power_i;
  wire bv_rise_w = bvalid_i && !bval_q && bvalid_rise_en_i;
  wire bv_fall_w = !bvalid_i && bval_q && bvalid_fall_en_i;
  wire alt_set_w = bv_rise_w || bv_fall_w;

  // ==========================================
  // command decode
  // noop is not a command
  wire cmd_seen_w = (data_i != UCS_CMD_NOOP);
  wire [1:0] typ_w = cmd_q[UCS_TYPE_MSB:UCS_TYPE_LSB];
  wire ext_w = (cmd_q[5:0] == UCS_PAY_EXT);
  wire is_tx_w = (typ_w == UCS_TYPE_TX);
  wire is_wr_w = (typ_w == UCS_TYPE_WR);
  wire [7:0] imm_w = {2'h0, cmd_q[5:0]};

  // ==========================================
  // sequencer
  always_comb begin
    st_d = st_q;
    dir_d = dir_q;
    nxt_d = nxt_q;
    data_d = data_q;
    oe_n_d = 1'b1;
    cmd_d = cmd_q;
    sent_d = sent_q;
    alt_clr_d = 1'b0;
    addr_d = addr_q;
    wdata_d = wdata_q;
    wr_d = 1'b0;
    rd_d = 1'b0;
    txb_d = txb_q;
    txv_d = 1'b0;
    txs_d = 1'b0;
    txe_d = 1'b0;
    first_d = first_q;
    case (st_q)
      S_IDLE: begin
        dir_d = 1'b0;
        nxt_d = 1'b0;
        if (!ta_q && cmd_seen_w) begin
          nxt_d = 1'b1;
          cmd_d = data_i;
          st_d = S_ACC;
        end else if (!ta_q && send_w) begin
          dir_d = 1'b1;
          st_d = S_SUP;
        end
      end
      S_ACC: begin
        if (is_tx_w) begin
          first_d = 1'b1;
          st_d = S_TX;
        end else if (ext_w) begin
          st_d = S_ADDR;
        end else if (is_wr_w) begin
          addr_d = imm_w;
          st_d = S_WDATA;
        end else begin
          addr_d = imm_w;
          nxt_d = 1'b0;
          dir_d = 1'b1;
          rd_d = 1'b1;
          st_d = S_RTA;
        end
      end
      S_ADDR: begin
        addr_d = data_i;
        if (is_wr_w) begin
          st_d = S_WDATA;
        end else begin
          nxt_d = 1'b0;
          dir_d = 1'b1;
          rd_d = 1'b1;
          st_d = S_RTA;
        end
      end
      S_WDATA: begin
        wdata_d = data_i;
        nxt_d = 1'b0;
        st_d = S_WSTP;
      end
      S_WSTP: begin
        if (stp_i) begin
          wr_d = 1'b1;
          st_d = S_IDLE;
        end
      end
      S_TX: begin
        if (stp_i) begin
          nxt_d = 1'b0;
          txe_d = 1'b1;
          st_d = S_IDLE;
        end else begin
          txb_d = data_i;
          txv_d = 1'b1;
          txs_d = first_q;
          first_d = 1'b0;
        end
      end
      S_RTA: begin
        data_d = rd_data_i;
        oe_n_d = 1'b0;
        st_d = S_RDRV;
      end
      S_RDRV: begin
        dir_d = 1'b0;
        st_d = S_IDLE;
      end
      S_SUP: begin
        data_d = status_w;
        oe_n_d = 1'b0;
        sent_d = status_w[6:0];
        alt_clr_d = 1'b1;
        st_d = S_SDRV;
      end
      S_SDRV: begin
        dir_d = 1'b0;
        st_d = S_IDLE;
      end
      default: begin
        dir_d = 1'b0;
        nxt_d = 1'b0;
        st_d = S_IDLE;
      end
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= S_IDLE;
      dir_q <= 1'b0;
      nxt_q <= 1'b0;
      data_q <= UCS_STATUS_RST;
      oe_n_q <= 1'b1;
      ta_q <= 1'b0;
      cmd_q <= UCS_CMD_NOOP;
    end else begin
      st_q <= st_d;
      dir_q <= dir_d;
      nxt_q <= nxt_d;
      data_q <= data_d;
      oe_n_q <= oe_n_d;
      ta_q <= dir_q ^ dir_d;
      cmd_q <= cmd_d;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sent_q <= UCS_STATUS_RST[6:0];
      alt_q <= 1'b0;
      bval_q <= 1'b0;
    end else begin
      sent_q <= sent_d;
      alt_q <= alt_set_w || (alt_q && !alt_clr_d);
      bval_q <= bvalid_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= 8'h00;
      wdata_q <= 8'h00;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      txb_q <= 8'h00;
      txv_q <= 1'b0;
      txs_q <= 1'b0;
      txe_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      txb_q <= txb_d;
      txv_q <= txv_d;
      txs_q <= txs_d;
      txe_q <= txe_d;
      first_q <= first_d;
    end
  end

  // ==========================================
  // outputs
  assign data_o = data_q;
  assign data_oe_n_o = oe_n_q;
  assign dir_o = dir_q;
  assign nxt_o = nxt_q;
  assign reg_addr_o = addr_q;
  assign reg_wdata_o = wdata_q;
  assign reg_wr_o = wr_q;
  assign reg_rd_o = rd_q;
  assign tx_pid_o = cmd_q[3:0];
  assign tx_byte_o = txb_q;
  assign tx_valid_o = txv_q;
  assign tx_start_o = txs_q;
  assign tx_end_o = txe_q;

  // ==========================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  a_nxt_dir_low: assert property (dir_o |-> !nxt_o)
    else $error("nxt high while dir high");

  a_rise_no_drive: assert property ($rose(dir_o) |-> data_oe_n_o)
    else $error("bus driven in turnaround");

  a_fall_quiet: assert property ($fell(dir_o) |-> !nxt_o ##1 !nxt_o)
    else $error("accept during turnaround");

  a_status_bits: assert property ((st_q == S_SUP) |=>
    !data_oe_n_o && dir_o && data_o[6:0] == $past(status_w[6:0]))
    else $error("status byte mismatch");

  a_fault_map: assert property ((external_indicator_select_i && indicator_passthrough_i) |->
    (vbus_w == UCS_VB_HOST_VLD) == fault_i) else $error("fault not on host vbus flag");

  a_change_sent: assert property ((st_q == S_IDLE && !ta_q &&
    !cmd_seen_w && send_w) |=> dir_o ##1 !data_oe_n_o)
    else $error("changed status not sent");

  a_alt_bit: assert property ((alt_q && st_q == S_SUP) |=> data_o[UCS_ALT_BIT])
    else $error("alternate bit missing");

  a_cmd_accept: assert property ((st_q == S_IDLE && !ta_q && cmd_seen_w)
    |=> nxt_o && !dir_o)
    else $error("command not accepted");

  a_tx_start: assert property (tx_start_o |-> $past(nxt_o) && tx_valid_o)
    else $error("transmit start without byte");

  a_fs_line: assert property ((!host_role_i && xcvr_select_i == 2'h1 &&
    term_select_i) |-> line_w == {dm_i, dp_i})
    else $error("full speed line state wrong");

  a_rx_event: assert property ((rx_active_i && rx_error_i &&
    !host_disconnect_i) |-> rxev_w == UCS_EV_ERROR)
    else $error("receive error code wrong");

  c_status_sent: cover property ((st_q == S_SUP) ##1 (st_q == S_SDRV));
  c_reg_write: cover property ((st_q == S_WSTP) ##1 reg_wr_o);
  c_reg_read: cover property (reg_rd_o ##1 !data_oe_n_o);
  c_tx_packet: cover property (tx_start_o ##[1:20] tx_end_o);
endmodule

// ### dv/ucs_link_model.sv
`timescale 1ns/1ps
// ==========================================
// link controller side of the shared bus
module ucs_link_model (
  input wire logic clk_i, // clock
  input wire logic dir_i, // device owns bus
  input wire logic nxt_i, // device accept
  input wire logic [7:0] dev_data_i, // device bus value
  input wire logic dev_oe_n_i, // device drives, low
  output logic [7:0] bus_o, // resolved bus level
  output logic stp_o // stop
);
  logic [7:0] drv_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic rd_pend = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic [7:0] stat_q[$];
  int hangs = 0;
  // ==========================================
  // bus level; a released bus toggles, no keeper
  // link off the bus while dir is high
  assign bus_o = !dev_oe_n_i ? dev_data_i : (!dir_i ? drv_q : ~last_q);
  initial stp_o = 1'b0;
  // take status bytes whenever no read is pending
  always @(posedge clk_i) begin
    last_q <= bus_o;
    if (dir_i === 1'b1 && dev_oe_n_i === 1'b0) begin
      if (rd_pend) begin
        rd_byte = dev_data_i;
        rd_pend = 1'b0;
      end else begin
        stat_q.push_back(dev_data_i);
      end
    end
  end
  // ==========================================
  // hold a byte until nxt is seen high
  task automatic send(input logic [7:0] b);
    int i;
    drv_q = b;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (nxt_i !== 1'b1 && i < 40);
    if (nxt_i !== 1'b1) hangs++;
    #1;
  endtask
  // noop on the bus during one stop cycle
  task automatic end_xfer;
    drv_q = 8'h00;
    stp_o = 1'b1;
    @(posedge clk_i);
    #1;
    stp_o = 1'b0;
  endtask
  task automatic reg_write(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] data);
    send(cmd);
    if (cmd[5:0] == 6'h2f) send(addr);
    send(data);
    end_xfer;
  endtask
  // read, then wait for the bus back
  task automatic reg_read(input logic [7:0] cmd, input logic [7:0] addr);
    int i;
    rd_pend = 1'b1;
    send(cmd);
    if (cmd[5:0] == 6'h2f) send(addr);
    drv_q = 8'h00;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while ((rd_pend || dir_i !== 1'b0) && i < 20);
    if (rd_pend) hangs++;
    #1;
  endtask
  task automatic xmit(input logic [7:0] cmd, input logic [31:0] bytes);
    send(cmd);
    for (int k = 0; k < 4; k++) send(bytes[8*k +: 8]);
    end_xfer;
  endtask
endmodule

// ### dv/testbench.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module testbench;
  import ucs_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [18:0] st = 19'h0;
  logic bvalid = 1'b0, rise_en = 1'b0, fall_en = 1'b0;
  logic [7:0] rd_data = 8'h00, bus, dout, reg_addr, reg_wdata, tx_byte, a;
  logic oe_n, stp, dir, nxt, reg_wr, reg_rd, tx_valid, tx_start, tx_end;
  logic [3:0] tx_pid;
  logic [5:0] p;
  logic [6:0] last6 = 7'h00;
  logic [31:0] r;
  logic prev_dir = 1'b0, first = 1'b1, lp = 1'b0;
  logic [7:0] exp_q[$];
  int n_errors = 0, num_checks = 0, n_wr = 0, n_rd = 0, n_end = 0, k, j, w0;
  always #20 clk_i = ~clk_i;
  ucs_port dut (.clk_i(clk_i), .reset_i(reset_i), .data_i(bus), .data_o(dout), .data_oe_n_o(oe_n),
    .stp_i(stp), .dir_o(dir), .nxt_o(nxt), .dp_i(st[10]), .dm_i(st[11]), .squelch_i(st[12]),
    .hs_diff_i(st[13]), .xcvr_select_i(st[15:14]), .term_select_i(st[16]), .chirp_mode_i(st[17]),
    .host_role_i(st[18]), .session_end_flag_i(st[9]), .session_valid_flag_i(st[8]),
    .host_vbus_cmp_i(st[7]), .fault_i(st[6]), .external_indicator_select_i(st[5]),
    .indicator_passthrough_i(st[4]), .rx_active_i(st[3]), .rx_error_i(st[2]), .host_disconnect_i(st[1]),
    .otg_role_pin_level_i(st[0]), .bvalid_i(bvalid), .bvalid_rise_en_i(rise_en),
    .bvalid_fall_en_i(fall_en), .low_power_i(lp), .rd_data_i(rd_data), .reg_addr_o(reg_addr),
    .reg_wdata_o(reg_wdata), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .tx_pid_o(tx_pid), .tx_byte_o(tx_byte),
    .tx_valid_o(tx_valid), .tx_start_o(tx_start), .tx_end_o(tx_end));
  ucs_link_model link (.clk_i(clk_i), .dir_i(dir), .nxt_i(nxt), .dev_data_i(dout), .dev_oe_n_i(oe_n),
    .bus_o(bus), .stp_o(stp));
  // ==========================================
  // reference model and helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction
  function automatic logic [6:0] exp_stat(input logic [18:0] s);
    logic [1:0] ls, vb, ev;
    logic ch;
    ch = s[18] ? s[17] : s[16];
    if (s[15:14] == 2'h0) ls = s[12] ? 2'h0 : (ch ? {~s[13], s[13]} : 2'h1);
    else if (s[18] && s[15:14] == 2'h2) ls = {s[10], s[11]};
    else ls = {s[11], s[10]};
    vb = ((s[5] && s[4]) ? s[6] : s[7]) ? 2'h3 : (s[8] ? 2'h2 : (s[9] ? 2'h0 : 2'h1));
    ev = s[1] ? 2'h2 : (s[3] ? {s[2], 1'b1} : 2'h0);
    return {s[0], ev, vb, ls};
  endfunction
  task automatic close_out;
    n_errors += link.hangs;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #1;
    if (link.hangs != 0) close_out;
  endtask
  task automatic chk_status(input logic alt);
    logic [6:0] e;
    int i;
    e = exp_stat(st);
    if (alt || e != last6) begin
      i = 0;
      while (link.stat_q.size() == 0 && i < 30) begin
        tick;
        i++;
      end
      if (i == 30) begin
        n_errors++;
        close_out;
      end
      check(link.stat_q[$] === {alt, e}, "status byte");
    end else begin
      repeat (8) tick;
      check(link.stat_q.size() == 0, "spurious status");
    end
    last6 = e;
    link.stat_q.delete();
  endtask
  // ==========================================
  // bus monitors
  always @(posedge clk_i) begin
    if (!reset_i) begin
      check(dir !== 1'b1 || nxt === 1'b0, "nxt high with dir");
      check(dir === prev_dir || oe_n === 1'b1, "no turnaround");
      if (tx_valid === 1'b1) begin
        check(exp_q.size() > 0 && tx_byte === exp_q[0], "tx byte");
        check(tx_start === first, "tx start");
        if (exp_q.size() > 0) void'(exp_q.pop_front());
        first = 1'b0;
      end
      if (reg_wr === 1'b1) n_wr++;
      if (reg_rd === 1'b1) n_rd++;
      if (tx_end === 1'b1) n_end++;
    end
    prev_dir = dir;
  end
  // ==========================================
  // main sequence
  initial begin
    r = 32'h8d141b13;
    repeat (12) @(posedge clk_i);
    #1 reset_i = 1'b0;
    chk_status(1'b0);
    for (k = 0; k < 80; k++) begin
      r = lfsr(r);
      st[r % 19] = ~st[r % 19];
      // fault routed with both select bits set
      if (k % 8 == 0) st[6:4] = {~st[6], 2'h3};
      chk_status(1'b0);
    end
    for (k = 0; k < 4; k++) begin
      rise_en = k[0];
      fall_en = k[1];
      tick;
      bvalid = 1'b1;
      chk_status(k[0]);
      bvalid = 1'b0;
      chk_status(k[1]);
    end
    for (k = 0; k < 8; k++) begin
      r = lfsr(r);
      rd_data = r[15:8];
      p = k[0] ? 6'h2f : (r[5:0] == 6'h2f ? 6'h2e : r[5:0]);
      a = k[0] ? r[23:16] : {2'h0, p};
      if (k[1]) begin
        w0 = n_wr;
        link.reg_write({2'h2, p}, a, r[31:24]);
        repeat (2) tick;
        check(n_wr == w0 + 1 && reg_addr === a && reg_wdata === r[31:24], "write");
      end else begin
        w0 = n_rd;
        link.reg_read({2'h3, p}, a);
        check(n_rd == w0 + 1 && reg_addr === a && link.rd_byte === rd_data, "read");
      end
    end
    for (k = 0; k < 4; k++) begin
      r = lfsr(r);
      p = (k == 0) ? 6'h00 : {2'h0, r[3:0] | 4'h1};
      first = 1'b1;
      w0 = n_end;
      for (j = 0; j < 4; j++) exp_q.push_back(r[8*j +: 8]);
      link.xmit({2'h1, p}, r);
      repeat (3) tick;
      check(exp_q.size() == 0 && n_end == w0 + 1 && tx_pid === p[3:0], "transmit");
    end
    // status held off in low power
    for (k = 0; k < 2; k++) begin
      lp = 1'b1;
      st[0] = ~st[0];
      repeat (8) tick;
      check(link.stat_q.size() == 0, "status in low power");
      if (k == 0) st[0] = ~st[0];
      lp = 1'b0;
      chk_status(1'b0);
    end
    chk_status(1'b0);
    close_out;
  end
endmodule
